// >>> pkg/lfp_pkg.sv
// package for the led driver protection and fault-flag block
package lfp_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] LFP_OFF_CTRL = 12'h000;
  localparam logic [11:0] LFP_OFF_STATUS = 12'h004;
  localparam logic [11:0] LFP_OFF_IRQ_STAT = 12'h008;
  localparam logic [11:0] LFP_OFF_IRQ_MASK = 12'h00C;
  localparam int LFP_CTRL_SHORT_DIS_BIT = 0;
  localparam logic [0:0] LFP_CTRL_RESET = 1'h0;
  localparam logic [6:0] LFP_IRQ_MASK_RESET = 7'h00;
  localparam int LFP_EVT_W = 7;

  // ****************************************
  // timing
  // ****************************************
  // switching-clock periods to latch-off (about 109 ms at 300 kHz)
  localparam int LFP_LATCH_COUNT = 32770;
  localparam int LFP_CNT_W = 16;

  // ****************************************
  // carriers
  // ****************************************
  // digitised comparator indications, all asynchronous to the core clock
  typedef struct packed {
    logic [3:0] pin_high;    // channel pin above 4.5 V
    logic [3:0] pin_low;     // channel pin below 0.3 V
    logic ovp_open;          // overvoltage sense at or above 1.7 V
    logic ovp_release;       // overvoltage sense below 1.45 V
    logic ovp_trip;          // overvoltage sense above 2.0 V
    logic overcurrent_protect;               // current sense below supply minus 0.6 V
    logic temp_cool;         // junction below 150 C
    logic temp_hot;          // junction above 175 C
    logic reg_ok;            // regulator above 3.5 V
    logic reg_low;           // regulator below 2.0 V
    logic supply_ok;         // supply above 4.0 V
    logic supply_low;        // supply below 3.5 V
  } lfp_cmp_t;

  // protection state, also the status register layout (low bits)
  typedef struct packed {
    logic [3:0] ch_short;
    logic [3:0] ch_open;
    logic low_power;
    logic short_circuit_protect;
    logic overvoltage_sense;
    logic overcurrent_protect;
    logic thermal_shutdown;
    logic undervoltage_lockout;
  } lfp_stat_t;

endpackage

// >>> core/lfp_top.sv
// protection, latch-off and fault-flag logic of a four-channel led driver
`timescale 1ns/1ps
// ****************************************
// Overview of operation
// R1: supply or regulator low shuts all but regulator; resume above 4.0V and 3.5V.
// R2: junction above 175C shuts all but regulator; release below 150C.
// R3: current sense low discharges soft-start, stops switching; releases automatically.
// R4: overvoltage above 2.0V discharges soft-start, stops switching; release below 1.45V.
// R5: channel pin low runs short-circuit counter; expiry latches all off until re-enable.
// R6: pin back above 0.3V before expiry resets counter, no latch.
// R7: fault counters clocked by switching clock; latch at count 32770.
// R8: pin low with overvoltage sense at 1.7V flags open, latches that channel.
// R9: pin above 4.5V runs short counter; expiry latches that channel until re-enable.
// R10: short condition evaluated only while pwm input is high.
// R11: short condition clearing before expiry resets counter, channel keeps running.
// R12: short detection disabled when disable pin high, active when low; the code also disables it while ctrl_short_dis is set.
// R13: system fault output low on lockout, thermal, overvoltage or short-circuit.
// R14: led fault output low on any channel open or short.
// R15: after enable a counter runs; pwm-off detection then enters reduced power.
// R16: host enables after supply, then pwm and sync after regulator up; the host model gates its switching clock on enable only.
// R17: two channel selects pick four, three, two or one active channels.
// R18: each enabled driver follows pwm input level directly.
// R19: all comparator indications synchronised before use.
// ****************************************
module lfp_top
  import lfp_pkg::*;
#(
  parameter int LATCH_COUNT = lfp_pkg::LFP_LATCH_COUNT
) (
  // clock, reset, enable
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  input wire logic I_CLK_EN,
  // pins from the host
  input wire logic I_EN,
  input wire logic I_PWM,
  input wire logic I_SHORT_DETECT_DISABLE,
  input wire logic I_CHANNEL_SELECT_A,
  input wire logic I_CHANNEL_SELECT_B,
  // switching clock and comparators
  input wire logic I_SW_CLK,
  input wire lfp_pkg::lfp_cmp_t I_CMP,
  // ahb-lite slave
  input wire logic I_HSEL,
  input wire logic [11:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic O_HREADYOUT,
  output logic [31:0] O_HRDATA,
  output logic O_HRESP,
  // fault pins, open drain
  output logic O_SYSTEM_FAULT_N_OUT,
  output logic O_SYSTEM_FAULT_N_OE,
  output logic O_LED_FAULT_N_OUT,
  output logic O_LED_FAULT_N_OE,
  // power stage controls
  output logic [3:0] O_CH_ON,
  output logic O_SS_DISCHARGE,
  output logic O_SWITCH_EN,
  output logic O_BLOCKS_ON,
  output logic O_LOW_POWER,
  // interrupt
  output logic O_IRQ
);
  import lfp_pkg::*;

  generate
    if (LATCH_COUNT < 2 || LATCH_COUNT > 65535) begin : g_chk
      $error("LATCH_COUNT out of range");
    end
  endgenerate

  localparam logic [LFP_CNT_W-1:0] LAST = LFP_CNT_W'(LATCH_COUNT - 1);
  localparam int SW = $bits(lfp_cmp_t) + 6;

  // ****************************************
  // input synchronisers
  // ****************************************
  // a change is believed only once stages two and three agree
  // edges closer than two core cycles are lost, so the switching clock must stay slow
  logic [SW-1:0] raw;
  logic [SW-1:0] s1;
  logic [SW-1:0] s2;
  logic [SW-1:0] s3;
  logic [SW-1:0] flt;
  assign raw = {I_CMP, I_EN, I_PWM, I_SHORT_DETECT_DISABLE, I_CHANNEL_SELECT_A, I_CHANNEL_SELECT_B, I_SW_CLK};

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      flt <= '0;
    end else if (I_CLK_EN) begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < SW; i++) begin
        if (s2[i] == s3[i]) begin
          flt[i] <= s3[i]; // R19
        end
      end
    end
  end

  lfp_cmp_t cmp;
  wire en = flt[5];
  wire pwm = flt[4];
  wire dis_pin = flt[3];
  wire sel_a = flt[2];
  wire sel_b = flt[1];
  wire sw_lvl = flt[0];
  assign cmp = flt[SW-1:6];

  // ****************************************
  // switching-clock tick
  // ****************************************
  logic sw_prev;
  wire sw_tick = sw_lvl & ~sw_prev; // R7

  // ****************************************
  // protection state
  // ****************************************
  logic undervoltage_lockout;
  logic thermal_shutdown;
  logic overvoltage_sense;
  logic overcurrent_protect;
  logic short_circuit_protect;
  logic low_power;
  logic [3:0] ch_open;
  logic [3:0] ch_short;
  logic [LFP_CNT_W-1:0] scp_cnt;
  logic [LFP_CNT_W-1:0] pwm_cnt;
  logic [LFP_CNT_W-1:0] sh_cnt [4];
  logic ctrl_short_dis;

  // latches clear on enable low (new enable) or lockout
  wire latch_clr = ~en | undervoltage_lockout; // R5 R9
  wire next_undervoltage_lockout = undervoltage_lockout ? ~(cmp.supply_ok & cmp.reg_ok) : (cmp.supply_low | cmp.reg_low); // R1
  wire next_tsd = thermal_shutdown ? ~cmp.temp_cool : cmp.temp_hot; // R2
  wire next_ovp = overvoltage_sense ? ~cmp.ovp_release : cmp.ovp_trip; // R4
  wire next_ocp = cmp.overcurrent_protect; // R3

  // channel select truth table
  wire [3:0] ch_sel = {~sel_a & ~sel_b, ~sel_b, ~sel_a | ~sel_b, 1'b1}; // R17
  wire [3:0] ch_live = ch_sel & ~ch_open & ~ch_short;
  wire blocks_run = en & ~undervoltage_lockout & ~thermal_shutdown & ~short_circuit_protect; // R1 R2 R5
  wire [3:0] open_hit = ch_live & cmp.pin_low & {4{cmp.ovp_open}}; // R8
  wire scp_cond = |(ch_live & cmp.pin_low & ~open_hit); // R5
  wire short_en = ~dis_pin & ~ctrl_short_dis; // R12
  wire [3:0] short_cond = ch_live & cmp.pin_high & {4{short_en}}; // R9
  wire [3:0] short_hit;
  wire sw_run = blocks_run & ~overcurrent_protect & ~overvoltage_sense & ~low_power; // R3 R4

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      sw_prev <= 1'b0;
      undervoltage_lockout <= 1'b1;
      thermal_shutdown <= 1'b0;
      overvoltage_sense <= 1'b0;
      overcurrent_protect <= 1'b0;
    end else if (I_CLK_EN) begin
      sw_prev <= sw_lvl;
      undervoltage_lockout <= next_undervoltage_lockout;
      thermal_shutdown <= next_tsd;
      overvoltage_sense <= next_ovp;
      overcurrent_protect <= next_ocp;
    end
  end

  // short-circuit counter: any selected pin low for the full count
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      scp_cnt <= '0;
      short_circuit_protect <= 1'b0;
    end else if (I_CLK_EN) begin
      if (latch_clr) begin
        scp_cnt <= '0;
        short_circuit_protect <= 1'b0;
      end else if (!scp_cond || short_circuit_protect) begin
        scp_cnt <= '0; // R6
      end else if (sw_tick) begin
        if (scp_cnt == LAST) begin
          short_circuit_protect <= 1'b1; // R5 R7
        end else begin
          scp_cnt <= scp_cnt + 1'b1;
        end
      end
    end
  end

  // per-channel short detection and open latch
  generate
    for (genvar c = 0; c < 4; c++) begin : g_ch
      assign short_hit[c] = sw_tick & pwm & short_cond[c] & (sh_cnt[c] == LAST);
      always_ff @(posedge I_CORE_CLK) begin
        if (!I_RSTN) begin
          sh_cnt[c] <= '0;
          ch_open[c] <= 1'b0;
          ch_short[c] <= 1'b0;
        end else if (I_CLK_EN) begin
          if (latch_clr) begin
            sh_cnt[c] <= '0;
            ch_open[c] <= 1'b0;
            ch_short[c] <= 1'b0;
          end else begin
            if (open_hit[c]) begin
              ch_open[c] <= 1'b1; // R8
            end
            // with pwm low the comparator is ignored and the count is held
            if (!pwm) begin
              sh_cnt[c] <= sh_cnt[c]; // R10
            end else if (!short_cond[c]) begin
              sh_cnt[c] <= '0; // R11
            end else if (short_hit[c]) begin
              ch_short[c] <= 1'b1; // R9 R7
              sh_cnt[c] <= '0;
            end else if (sw_tick) begin
              sh_cnt[c] <= sh_cnt[c] + 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // pwm-off detection: enable must have been on, pwm low for the full count
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      pwm_cnt <= '0;
      low_power <= 1'b0;
    end else if (I_CLK_EN) begin
      if (!en || undervoltage_lockout || pwm) begin
        pwm_cnt <= '0;
        low_power <= 1'b0;
      end else if (sw_tick && !low_power) begin
        if (pwm_cnt == LAST) begin
          low_power <= 1'b1; // R15
        end else begin
          pwm_cnt <= pwm_cnt + 1'b1;
        end
      end
    end
  end

  // ****************************************
  // status and interrupt events
  // ****************************************
  lfp_stat_t stat;
  lfp_stat_t stat_prev;
  assign stat = '{ch_short: ch_short, ch_open: ch_open, low_power: low_power, short_circuit_protect: short_circuit_protect, overvoltage_sense: overvoltage_sense, overcurrent_protect: overcurrent_protect,
                  thermal_shutdown: thermal_shutdown, undervoltage_lockout: undervoltage_lockout};
  wire [LFP_EVT_W-1:0] evt_lvl = {|stat.ch_short, |stat.ch_open, stat.short_circuit_protect, stat.overvoltage_sense, stat.overcurrent_protect, stat.thermal_shutdown, stat.undervoltage_lockout};
  wire [LFP_EVT_W-1:0] evt_prev = {|stat_prev.ch_short, |stat_prev.ch_open, stat_prev.short_circuit_protect, stat_prev.overvoltage_sense,
                                   stat_prev.overcurrent_protect, stat_prev.thermal_shutdown, stat_prev.undervoltage_lockout};
  wire [LFP_EVT_W-1:0] evt = evt_lvl & ~evt_prev;
  logic [LFP_EVT_W-1:0] irq_stat;
  logic [LFP_EVT_W-1:0] irq_mask;

  // ****************************************
  // ahb-lite slave
  // ****************************************
  // one wait state so that read data leave a flip-flop
  logic pend;
  logic pend_wr;
  logic [11:0] pend_addr;
  wire take = I_HSEL & I_HTRANS[1] & I_HREADY;
  wire sel_ctrl = pend_addr == LFP_OFF_CTRL;
  wire sel_stat = pend_addr == LFP_OFF_STATUS;
  wire sel_istat = pend_addr == LFP_OFF_IRQ_STAT;
  wire sel_imask = pend_addr == LFP_OFF_IRQ_MASK;
  wire wr_now = pend & pend_wr;
  wire [LFP_EVT_W-1:0] w1c = (wr_now & sel_istat) ? I_HWDATA[LFP_EVT_W-1:0] : '0;
  // a new event wins over a clear in the same cycle
  wire [LFP_EVT_W-1:0] next_irq_stat = (irq_stat & ~w1c) | evt;
  wire [31:0] rd_mux = sel_ctrl ? {31'h0, ctrl_short_dis} :
                       sel_stat ? {18'h0, stat} :
                       sel_istat ? {25'h0, irq_stat} :
                       sel_imask ? {25'h0, irq_mask} : 32'h0;

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      pend <= 1'b0;
      pend_wr <= 1'b0;
      pend_addr <= 12'h000;
      O_HREADYOUT <= 1'b1;
      O_HRDATA <= 32'h0;
      O_HRESP <= 1'b0;
      ctrl_short_dis <= LFP_CTRL_RESET;
      irq_mask <= LFP_IRQ_MASK_RESET;
      irq_stat <= '0;
      stat_prev <= '0;
    end else if (I_CLK_EN) begin
      stat_prev <= stat;
      irq_stat <= next_irq_stat;
      if (pend) begin
        pend <= 1'b0;
        O_HREADYOUT <= 1'b1;
        O_HRDATA <= pend_wr ? 32'h0 : rd_mux;
        if (pend_wr && sel_ctrl) begin
          ctrl_short_dis <= I_HWDATA[LFP_CTRL_SHORT_DIS_BIT];
        end
        if (pend_wr && sel_imask) begin
          irq_mask <= I_HWDATA[LFP_EVT_W-1:0];
        end
      end else if (take) begin
        pend <= 1'b1;
        pend_wr <= I_HWRITE;
        pend_addr <= {I_HADDR[11:2], 2'b00};
        O_HREADYOUT <= 1'b0;
      end
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RSTN) begin
      O_SYSTEM_FAULT_N_OUT <= 1'b0;
      O_SYSTEM_FAULT_N_OE <= 1'b0;
      O_LED_FAULT_N_OUT <= 1'b0;
      O_LED_FAULT_N_OE <= 1'b0;
      O_CH_ON <= 4'h0;
      O_SS_DISCHARGE <= 1'b1;
      O_SWITCH_EN <= 1'b0;
      O_BLOCKS_ON <= 1'b0;
      O_LOW_POWER <= 1'b0;
      O_IRQ <= 1'b0;
    end else if (I_CLK_EN) begin
      O_SYSTEM_FAULT_N_OE <= undervoltage_lockout | thermal_shutdown | overvoltage_sense | short_circuit_protect; // R13
      O_LED_FAULT_N_OE <= |(ch_open | ch_short); // R14
      O_CH_ON <= {4{blocks_run & pwm}} & ch_live; // R18 R17
      O_SS_DISCHARGE <= ~sw_run; // R3 R4
      O_SWITCH_EN <= sw_run;
      O_BLOCKS_ON <= blocks_run;
      O_LOW_POWER <= low_power;
      O_IRQ <= |(next_irq_stat & irq_mask);
    end
  end

endmodule

// >>> test/lfp_top_assertions.sv
// assertions on the ports of the led driver protection block
`timescale 1ns/1ps
module lfp_top_assertions
  import lfp_pkg::*;
#(
  parameter int LATCH_COUNT = lfp_pkg::LFP_LATCH_COUNT
) (
  // clock and reset
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  // host pins and comparators
  input wire logic I_PWM,
  input wire logic I_CHANNEL_SELECT_A,
  input wire logic I_CHANNEL_SELECT_B,
  input wire lfp_pkg::lfp_cmp_t I_CMP,
  // outputs watched
  input wire logic O_SYSTEM_FAULT_N_OE,
  input wire logic [3:0] O_CH_ON,
  input wire logic O_SS_DISCHARGE,
  input wire logic O_SWITCH_EN,
  input wire logic O_BLOCKS_ON
);
  // ********
  // properties
  // ********
  // eight cycles cover the input filter plus state and output flops
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RSTN);
  property p_sw;
    O_SWITCH_EN == !O_SS_DISCHARGE;
  endproperty
  a_sw: assert property (p_sw) else $error("switching allowed while discharging");
  property p_selb;
    I_CHANNEL_SELECT_B [*8] |-> O_CH_ON[3:2] == 2'h0;
  endproperty
  a_selb: assert property (p_selb) else $error("channels 3-4 on with select b");
  property p_sela;
    I_CHANNEL_SELECT_A [*8] |-> !O_CH_ON[3];
  endproperty
  a_sela: assert property (p_sela) else $error("channel 4 on with select a");
  property p_pwm;
    !I_PWM [*8] |-> O_CH_ON == 4'h0;
  endproperty
  a_pwm: assert property (p_pwm) else $error("driver on while pwm low");
  property p_undervoltage_lockout;
    I_CMP.supply_low [*8] |-> !O_BLOCKS_ON && O_SYSTEM_FAULT_N_OE;
  endproperty
  a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("lockout not applied");
  property p_hot;
    I_CMP.temp_hot [*8] |-> !O_BLOCKS_ON;
  endproperty
  a_hot: assert property (p_hot) else $error("thermal shutdown not applied");
  property p_ovp;
    I_CMP.ovp_trip [*8] |-> O_SS_DISCHARGE && O_SYSTEM_FAULT_N_OE;
  endproperty
  a_ovp: assert property (p_ovp) else $error("overvoltage not applied");
  property p_ocp;
    I_CMP.overcurrent_protect [*8] |-> O_SS_DISCHARGE;
  endproperty
  a_ocp: assert property (p_ocp) else $error("overcurrent not applied");
endmodule

bind lfp_top lfp_top_assertions #(.LATCH_COUNT(LATCH_COUNT)) lfp_top_assertions_inst (
  .I_CORE_CLK, .I_RSTN, .I_PWM, .I_CHANNEL_SELECT_A, .I_CHANNEL_SELECT_B, .I_CMP,
  .O_SYSTEM_FAULT_N_OE, .O_CH_ON, .O_SS_DISCHARGE, .O_SWITCH_EN, .O_BLOCKS_ON
);

// >>> test/lfp_host_model.sv
// host controller model driving enable, pwm and the switching clock
`timescale 1ns/1ps
module lfp_host_model
  import lfp_pkg::*;
(
  // requests from the bench
  input wire logic i_want_en,
  input wire logic i_want_pwm,
  // indications the host can see
  input wire lfp_pkg::lfp_cmp_t i_cmp,
  // pins to the device
  output logic o_en,
  output logic o_pwm,
  output logic o_sw_clk
);
  // ********
  // pins
  // ********
  assign o_en = i_want_en & i_cmp.supply_ok;
  assign o_pwm = o_en & i_want_pwm & i_cmp.reg_ok;
  // stands low while disabled; 400 ns keeps edges far apart for the filter
  initial begin
    o_sw_clk = 1'b0;
    forever #200 o_sw_clk = o_en ? ~o_sw_clk : 1'b0;
  end
endmodule

// >>> test/testbench.sv
// self-checking bench for the led driver protection block
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; $display("mismatch %s exp %h got %h", n, e, g); end end
module testbench;
  import lfp_pkg::*;
  // ********
  // signals
  // ********
  // a small count keeps each latch-off about 128 core cycles
  localparam int LC = 8;
  logic clk, rstn, wen, wpwm, sdis, sela, selb, hsel, hwr, hrdy, en, pwm, swclk, hresp;
  logic sf, sfo, lf, lfo, ss, swen, bl, lp, irq, cen;
  logic [1:0] htr;
  logic [11:0] ha;
  logic [31:0] hwd, hrd, rd;
  logic [3:0] ch;
  lfp_cmp_t cmp;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  // open-drain pins with pull-up
  wire sf_n = sfo ? sf : 1'b1;
  wire lf_n = lfo ? lf : 1'b1;
  lfp_top #(.LATCH_COUNT(LC)) lfp_top_inst (
    .I_CORE_CLK(clk), .I_RSTN(rstn), .I_CLK_EN(cen), .I_EN(en), .I_PWM(pwm),
    .I_SHORT_DETECT_DISABLE(sdis), .I_CHANNEL_SELECT_A(sela), .I_CHANNEL_SELECT_B(selb),
    .I_SW_CLK(swclk), .I_CMP(cmp), .I_HSEL(hsel), .I_HADDR(ha), .I_HTRANS(htr), .I_HWRITE(hwr),
    .I_HSIZE(3'h2), .I_HWDATA(hwd), .I_HREADY(hrdy), .O_HREADYOUT(hrdy), .O_HRDATA(hrd),
    .O_HRESP(hresp), .O_SYSTEM_FAULT_N_OUT(sf), .O_SYSTEM_FAULT_N_OE(sfo), .O_LED_FAULT_N_OUT(lf),
    .O_LED_FAULT_N_OE(lfo), .O_CH_ON(ch), .O_SS_DISCHARGE(ss), .O_SWITCH_EN(swen),
    .O_BLOCKS_ON(bl), .O_LOW_POWER(lp), .O_IRQ(irq)
  );
  lfp_host_model lfp_host_model_inst (
    .i_want_en(wen), .i_want_pwm(wpwm), .i_cmp(cmp), .o_en(en), .o_pwm(pwm), .o_sw_clk(swclk)
  );
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      end_sim();
    end
  end
  // ********
  // tasks
  // ********
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic tk(input int n);
    wt(n * 16);
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htr <= 2'h2;
    hwr <= w;
    ha <= a;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htr <= 2'h0;
    hwd <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrd;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rd);
    `CHK("rdata", e, rd)
    `CHK("hresp", 1'b0, hresp)
  endtask
  task automatic reen();
    wen <= 1'b0;
    wt(12);
    wen <= 1'b1;
    wt(12);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_reset();
    wt(1);
    `CHK("blocks", 1'b0, bl)
    rchk(LFP_OFF_CTRL, 32'h0);
    rchk(LFP_OFF_IRQ_MASK, 32'h0);
    rchk(12'h010, 32'h0);
  endtask
  task automatic t_power();
    cmp.supply_ok <= 1'b1;
    cmp.reg_ok <= 1'b1;
    cmp.temp_cool <= 1'b1;
    cmp.ovp_release <= 1'b1;
    wen <= 1'b1;
    wpwm <= 1'b1;
    wt(12);
    `CHK("blocks", 1'b1, bl)
    `CHK("sf_n", 1'b1, sf_n)
    `CHK("swen", 1'b1, swen)
    bus(1'b1, LFP_OFF_IRQ_STAT, 32'h7F, rd);
    bus(1'b1, LFP_OFF_IRQ_MASK, 32'h7F, rd);
    rchk(LFP_OFF_IRQ_STAT, 32'h0);
  endtask
  task automatic t_select();
    for (int i = 0; i < 4; i++) begin
      {selb, sela} <= i[1:0];
      wt(10);
      `CHK("ch_on", 4'hF >> i, ch)
    end
    {selb, sela} <= 2'h0;
    wt(10);
  endtask
  task automatic t_lowpw();
    wpwm <= 1'b0;
    tk(LC - 3);
    `CHK("low_pw", 1'b0, lp)
    tk(6);
    `CHK("low_pw", 1'b1, lp)
    wpwm <= 1'b1;
    wt(12);
    `CHK("low_pw", 1'b0, lp)
  endtask
  task automatic t_scp();
    cmp.pin_low[0] <= 1'b1;
    tk(LC - 3);
    cmp.pin_low[0] <= 1'b0;
    wt(10);
    cmp.pin_low[0] <= 1'b1;
    tk(LC - 3);
    `CHK("sf_n", 1'b1, sf_n)
    tk(6);
    `CHK("sf_n", 1'b0, sf_n)
    `CHK("blocks", 1'b0, bl)
    `CHK("irq", 1'b1, irq)
    rchk(LFP_OFF_IRQ_STAT, 32'h10);
    bus(1'b1, LFP_OFF_IRQ_MASK, 32'h0, rd);
    wt(2);
    `CHK("irq", 1'b0, irq)
    bus(1'b1, LFP_OFF_IRQ_STAT, 32'h10, rd);
    rchk(LFP_OFF_IRQ_STAT, 32'h0);
    cmp.pin_low[0] <= 1'b0;
    reen();
    `CHK("blocks", 1'b1, bl)
  endtask
  task automatic t_open();
    cen <= 1'b0;
    cmp.ovp_open <= 1'b1;
    cmp.pin_low[1] <= 1'b1;
    wt(12);
    `CHK("lf_n", 1'b1, lf_n)
    `CHK("ch_on", 4'hF, ch)
    cen <= 1'b1;
    wt(12);
    `CHK("lf_n", 1'b0, lf_n)
    `CHK("ch_on", 4'hD, ch)
    rchk(LFP_OFF_IRQ_STAT, 32'h20);
    cmp.ovp_open <= 1'b0;
    cmp.pin_low[1] <= 1'b0;
    reen();
    `CHK("lf_n", 1'b1, lf_n)
  endtask
  task automatic t_short();
    sdis <= 1'b1;
    cmp.pin_high[2] <= 1'b1;
    tk(LC + 3);
    `CHK("lf_n", 1'b1, lf_n)
    bus(1'b1, LFP_OFF_CTRL, 32'h1, rd);
    sdis <= 1'b0;
    rchk(LFP_OFF_CTRL, 32'h1);
    tk(LC + 3);
    `CHK("lf_n", 1'b1, lf_n)
    bus(1'b1, LFP_OFF_CTRL, 32'h0, rd);
    tk(LC - 3);
    cmp.pin_high[2] <= 1'b0;
    wt(10);
    cmp.pin_high[2] <= 1'b1;
    tk(LC - 3);
    `CHK("lf_n", 1'b1, lf_n)
    wpwm <= 1'b0;
    tk(LC);
    `CHK("lf_n", 1'b1, lf_n)
    wpwm <= 1'b1;
    tk(6);
    `CHK("lf_n", 1'b0, lf_n)
    `CHK("ch_on", 4'hB, ch)
    cmp.pin_high[2] <= 1'b0;
    reen();
  endtask
  task automatic t_prot();
    cmp.ovp_release <= 1'b0;
    cmp.ovp_trip <= 1'b1;
    wt(12);
    `CHK("ss", 1'b1, ss)
    `CHK("swen", 1'b0, swen)
    `CHK("blocks", 1'b1, bl)
    `CHK("sf_n", 1'b0, sf_n)
    cmp.ovp_trip <= 1'b0;
    wt(12);
    `CHK("ss", 1'b1, ss)
    `CHK("sf_n", 1'b0, sf_n)
    cmp.ovp_release <= 1'b1;
    cmp.temp_cool <= 1'b0;
    cmp.temp_hot <= 1'b1;
    wt(12);
    `CHK("blocks", 1'b0, bl)
    `CHK("sf_n", 1'b0, sf_n)
    cmp.temp_hot <= 1'b0;
    wt(12);
    `CHK("blocks", 1'b0, bl)
    cmp.temp_cool <= 1'b1;
    cmp.overcurrent_protect <= 1'b1;
    wt(12);
    `CHK("ss", 1'b1, ss)
    `CHK("blocks", 1'b1, bl)
    cmp.overcurrent_protect <= 1'b0;
    wt(12);
    `CHK("ss", 1'b0, ss)
    `CHK("swen", 1'b1, swen)
    cmp.supply_ok <= 1'b0;
    cmp.supply_low <= 1'b1;
    wt(12);
    `CHK("sf_n", 1'b0, sf_n)
  endtask
  initial begin
    rstn = 1'b0;
    {wen, wpwm, sdis, sela, selb, hsel, hwr} = '0;
    htr = 2'h0;
    cen = 1'b1;
    ha = 12'h0;
    hwd = 32'h0;
    cmp = '0;
    wt(16);
    rstn <= 1'b1;
    t_reset();
    t_power();
    t_select();
    t_lowpw();
    t_scp();
    t_open();
    t_short();
    t_prot();
    end_sim();
  end
endmodule
